// ### hdpc_bank.sv
// Hub descriptor and power configuration bank with string descriptor output.
`timescale 1ns/10ps
`include "hdpc_regs.svh"
module hdpc_bank
	import hdpc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire hdpc_cfg_req_s cfg_req,
	output logic [7:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic desc_req,
	input wire hdpc_desc_sel_e desc_sel,
	input wire logic desc_ready,
	output hdpc_desc_out_s desc_out,
	output logic desc_busy,
	output hdpc_power_s power,
	output logic [8:0] self_powered_current_ma,
	output logic [8:0] bus_powered_current_ma,
	output logic [8:0] port_power_settle_ms
);
	hdpc_bank_s s;
	hdpc_bank_s next_s;
	hdpc_area_e wr_area;
	hdpc_area_e rd_area;
	logic text_wr;
	logic [7:0] cfg_index;
	logic [7:0] desc_index;
	logic [7:0] cfg_text;
	logic [7:0] desc_text;
	logic [2:0][7:0] counts;
	logic [2:0][8:0] amounts;

	assign wr_area = hdpc_area_of(cfg_req.addr);
	assign rd_area = hdpc_area_of(cfg_req.addr);
	assign text_wr = cfg_req.write && (wr_area == HDPC_AREA_TEXT);
	// Text bytes map straight onto memory, one address per byte.
	assign cfg_index = cfg_req.addr - `HDPC_MAKER_TEXT_FIRST; // [R14] [R16]
	assign desc_index = s.base + {2'h0, s.idx}; // [R19]

	hdpc_text_mem u_text_mem (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(text_wr),
		.wr_index(cfg_index),
		.wr_data(cfg_req.wdata),
		.cfg_index(cfg_index),
		.cfg_data(cfg_text),
		.desc_index(desc_index),
		.desc_data(desc_text)
	);

	// The stored counts already exclude any embedded compound peripheral,
	// so they are reported untouched; software must budget for it.
	assign counts = {s.settle, s.bp, s.sp}; // [R02] [R05]

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_scale
			hdpc_unit_scale u_scale (
				.count(counts[g]),
				.amount(amounts[g])
			);
		end
	endgenerate

	assign self_powered_current_ma = amounts[0]; // [R01]
	assign bus_powered_current_ma = amounts[1]; // [R04]
	assign port_power_settle_ms = amounts[2]; // [R08]

	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;

		// Configuration writes; unmapped addresses are silently ignored.
		if (cfg_req.write) begin
			case (wr_area)
				HDPC_AREA_SELF: begin
					next_s.sp = cfg_req.wdata; // [R01]
				end
				HDPC_AREA_BUS: begin
					next_s.bp = cfg_req.wdata; // [R04]
				end
				HDPC_AREA_SETTLE: begin
					next_s.settle = cfg_req.wdata; // [R08]
				end
				HDPC_AREA_LANG_HIGH: begin
					next_s.lang_high = cfg_req.wdata; // [R09]
				end
				HDPC_AREA_LANG_LOW: begin
					next_s.lang_low = cfg_req.wdata; // [R10]
				end
				HDPC_AREA_MAKER_LEN: begin
					next_s.maker_len = cfg_req.wdata; // [R11]
				end
				HDPC_AREA_ITEM_LEN: begin
					next_s.item_len = cfg_req.wdata; // [R12]
				end
				HDPC_AREA_UNIT_LEN: begin
					next_s.unit_len = cfg_req.wdata; // [R13]
				end
				default: begin
				end
			endcase
		end

		// Reads capture scalars in the request cycle so that a write in the
		// same cycle is seen by neither scalar nor text reads.
		next_s.rd_pend = cfg_req.read;
		next_s.rd_text = (rd_area == HDPC_AREA_TEXT);
		case (rd_area)
			HDPC_AREA_SELF: begin
				next_s.rd_scalar = s.sp;
			end
			HDPC_AREA_BUS: begin
				next_s.rd_scalar = s.bp;
			end
			HDPC_AREA_SETTLE: begin
				next_s.rd_scalar = s.settle;
			end
			HDPC_AREA_LANG_HIGH: begin
				next_s.rd_scalar = s.lang_high;
			end
			HDPC_AREA_LANG_LOW: begin
				next_s.rd_scalar = s.lang_low;
			end
			HDPC_AREA_MAKER_LEN: begin
				next_s.rd_scalar = s.maker_len;
			end
			HDPC_AREA_ITEM_LEN: begin
				next_s.rd_scalar = s.item_len;
			end
			HDPC_AREA_UNIT_LEN: begin
				next_s.rd_scalar = s.unit_len;
			end
			default: begin
				next_s.rd_scalar = 8'h00;
			end
		endcase
		if (s.rd_pend) begin
			next_s.rdata = s.rd_text ? cfg_text : s.rd_scalar;
			next_s.rvalid = 1'b1;
		end

		// Descriptor streaming toward the upstream host.
		case (s.fsm)
			HDPC_IDLE: begin
				if (desc_req) begin
					next_s.sel = desc_sel;
					next_s.idx = 6'h00;
					if (desc_sel == HDPC_DESC_LANG) begin
						next_s.busy = 1'b1;
						next_s.total = 6'h02;
						next_s.out.data = s.lang_low; // [R10]
						next_s.out.valid = 1'b1;
						next_s.out.last = 1'b0;
						next_s.fsm = HDPC_SEND;
					end else begin
						case (desc_sel)
							HDPC_DESC_MAKER: begin
								// [R11] [R14]
								next_s.total = {hdpc_clamp_chars(s.maker_len), 1'b0};
								next_s.base = `HDPC_MAKER_INDEX;
							end
							HDPC_DESC_ITEM: begin
								// [R12] [R16] [R17]
								next_s.total = {hdpc_clamp_chars(s.item_len), 1'b0};
								next_s.base = `HDPC_ITEM_INDEX;
							end
							default: begin
								// [R13] [R18]
								next_s.total = {hdpc_clamp_chars(s.unit_len), 1'b0};
								next_s.base = `HDPC_UNIT_INDEX;
							end
						endcase
						// An empty string is absorbed and sends nothing.
						if (next_s.total != 6'h00) begin
							next_s.busy = 1'b1;
							next_s.fsm = HDPC_READ;
						end
					end
				end
			end
			HDPC_READ: begin
				next_s.fsm = HDPC_LOAD;
			end
			HDPC_LOAD: begin
				next_s.out.data = desc_text; // [R15] [R19]
				next_s.out.valid = 1'b1;
				next_s.out.last = (s.idx == s.total - 6'h01); // [R19]
				next_s.fsm = HDPC_SEND;
			end
			HDPC_SEND: begin
				if (desc_ready) begin
					next_s.out.valid = 1'b0;
					next_s.out.last = 1'b0;
					if (s.out.last) begin
						next_s.busy = 1'b0;
						next_s.fsm = HDPC_IDLE;
					end else begin
						next_s.idx = s.idx + 6'h01;
						if (s.sel == HDPC_DESC_LANG) begin
							next_s.out.data = s.lang_high; // [R09]
							next_s.out.valid = 1'b1;
							next_s.out.last = 1'b1;
						end else begin
							next_s.fsm = HDPC_READ;
						end
					end
				end
			end
			default: begin
				next_s.fsm = HDPC_IDLE;
				next_s.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.sp <= `HDPC_CURRENT_RESET; // [R03]
			s.bp <= `HDPC_CURRENT_RESET; // [R06]
			s.settle <= `HDPC_PLAIN_RESET;
			s.lang_high <= `HDPC_PLAIN_RESET;
			s.lang_low <= `HDPC_PLAIN_RESET;
			s.maker_len <= `HDPC_PLAIN_RESET;
			s.item_len <= `HDPC_PLAIN_RESET;
			s.unit_len <= `HDPC_PLAIN_RESET;
			s.fsm <= HDPC_IDLE;
			s.sel <= HDPC_DESC_LANG;
		end else begin
			s <= next_s;
		end
	end

	assign cfg_rdata = s.rdata;
	assign cfg_rvalid = s.rvalid;
	assign desc_out = s.out;
	assign desc_busy = s.busy;
	assign power.self_count = s.sp;
	assign power.bus_count = s.bp;
	assign power.settle_count = s.settle;
	assign power.language_id = {s.lang_high, s.lang_low}; // [R09] [R10]
endmodule // hdpc_bank

// ### hdpc_regs.svh
// Offsets, field limits and reset values of the hub descriptor config bank.
// Overview of operation
// (R01) Self-powered current counts 2 mA each.
// (R02) Self-powered count excludes embedded compound peripheral.
// (R03) Self-powered current resets to 50, 100 mA.
// (R04) Bus-powered current counts 2 mA each.
// (R05) Bus-powered count excludes embedded compound peripheral.
// (R06) Bus-powered current resets to 50, 100 mA.
// (R07) Programmer keeps self-powered current within 100 mA.
// (R08) Port power settle time counts 2 ms.
// (R09) High register gives language identifier bits 15:8.
// (R10) Low register gives language identifier bits 7:0.
// (R11) Maker text length, at most 31 characters.
// (R12) Item text length, at most 31 characters.
// (R13) Unit number text length, at most 31 characters.
// (R14) Maker text lives at 16h-53h, UTF-16LE.
// (R15) Character low byte first, ascending contiguous.
// (R16) Item text lives at 54h-91h, 62 bytes.
// (R17) Item text characters are UTF-16LE.
// (R18) Unit number text lives at 92h-CFh.
// (R19) Descriptor sends twice length bytes, ascending.
`ifndef HDPC_REGS_SVH
`define HDPC_REGS_SVH

`define HDPC_SELF_CURRENT_OFS 8'h0E
`define HDPC_BUS_CURRENT_OFS 8'h0F
`define HDPC_SETTLE_OFS 8'h10
`define HDPC_LANG_HIGH_OFS 8'h11
`define HDPC_LANG_LOW_OFS 8'h12
`define HDPC_MAKER_LEN_OFS 8'h13
`define HDPC_ITEM_LEN_OFS 8'h14
`define HDPC_UNIT_LEN_OFS 8'h15
`define HDPC_MAKER_TEXT_FIRST 8'h16
`define HDPC_MAKER_TEXT_LAST 8'h53
`define HDPC_ITEM_TEXT_FIRST 8'h54
`define HDPC_ITEM_TEXT_LAST 8'h91
`define HDPC_UNIT_TEXT_FIRST 8'h92
`define HDPC_UNIT_TEXT_LAST 8'hCF
`define HDPC_TEXT_BYTES 186
`define HDPC_CURRENT_RESET 8'h32
`define HDPC_PLAIN_RESET 8'h00
`define HDPC_MAX_CHARS 5'h1F
`define HDPC_MAKER_INDEX 8'h00
`define HDPC_ITEM_INDEX 8'h3E
`define HDPC_UNIT_INDEX 8'h7C

`endif

// ### hdpc_pkg.sv
// Types and decode functions shared by the hub descriptor config bank.
`include "hdpc_regs.svh"
package hdpc_pkg;

	typedef enum logic [3:0] {
		HDPC_AREA_NONE = 4'h0,
		HDPC_AREA_SELF = 4'h1,
		HDPC_AREA_BUS = 4'h2,
		HDPC_AREA_SETTLE = 4'h3,
		HDPC_AREA_LANG_HIGH = 4'h4,
		HDPC_AREA_LANG_LOW = 4'h5,
		HDPC_AREA_MAKER_LEN = 4'h6,
		HDPC_AREA_ITEM_LEN = 4'h7,
		HDPC_AREA_UNIT_LEN = 4'h8,
		HDPC_AREA_TEXT = 4'h9
	} hdpc_area_e;

	typedef enum logic [1:0] {
		HDPC_DESC_LANG = 2'h0,
		HDPC_DESC_MAKER = 2'h1,
		HDPC_DESC_ITEM = 2'h2,
		HDPC_DESC_UNIT = 2'h3
	} hdpc_desc_sel_e;

	typedef enum logic [1:0] {
		HDPC_IDLE = 2'h0,
		HDPC_READ = 2'h1,
		HDPC_LOAD = 2'h2,
		HDPC_SEND = 2'h3
	} hdpc_fsm_e;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hdpc_cfg_req_s;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} hdpc_desc_out_s;

	typedef struct packed {
		logic [7:0] self_count;
		logic [7:0] bus_count;
		logic [7:0] settle_count;
		logic [15:0] language_id;
	} hdpc_power_s;

	typedef struct packed {
		logic [7:0] sp;
		logic [7:0] bp;
		logic [7:0] settle;
		logic [7:0] lang_high;
		logic [7:0] lang_low;
		logic [7:0] maker_len;
		logic [7:0] item_len;
		logic [7:0] unit_len;
		hdpc_fsm_e fsm;
		hdpc_desc_sel_e sel;
		logic [5:0] idx;
		logic [5:0] total;
		logic [7:0] base;
		hdpc_desc_out_s out;
		logic busy;
		logic rd_pend;
		logic rd_text;
		logic [7:0] rd_scalar;
		logic [7:0] rdata;
		logic rvalid;
	} hdpc_bank_s;

	function automatic hdpc_area_e hdpc_area_of(input logic [7:0] addr);
		if (addr == `HDPC_SELF_CURRENT_OFS) hdpc_area_of = HDPC_AREA_SELF;
		else if (addr == `HDPC_BUS_CURRENT_OFS) hdpc_area_of = HDPC_AREA_BUS;
		else if (addr == `HDPC_SETTLE_OFS) hdpc_area_of = HDPC_AREA_SETTLE;
		else if (addr == `HDPC_LANG_HIGH_OFS) hdpc_area_of = HDPC_AREA_LANG_HIGH;
		else if (addr == `HDPC_LANG_LOW_OFS) hdpc_area_of = HDPC_AREA_LANG_LOW;
		else if (addr == `HDPC_MAKER_LEN_OFS) hdpc_area_of = HDPC_AREA_MAKER_LEN;
		else if (addr == `HDPC_ITEM_LEN_OFS) hdpc_area_of = HDPC_AREA_ITEM_LEN;
		else if (addr == `HDPC_UNIT_LEN_OFS) hdpc_area_of = HDPC_AREA_UNIT_LEN;
		else if (addr >= `HDPC_MAKER_TEXT_FIRST && addr <= `HDPC_UNIT_TEXT_LAST)
			hdpc_area_of = HDPC_AREA_TEXT;
		else hdpc_area_of = HDPC_AREA_NONE;
	endfunction

	function automatic logic [4:0] hdpc_clamp_chars(input logic [7:0] len);
		if (len > {3'h0, `HDPC_MAX_CHARS}) hdpc_clamp_chars = `HDPC_MAX_CHARS;
		else hdpc_clamp_chars = len[4:0];
	endfunction

endpackage

// ### hdpc_text_mem.sv
// Byte memory holding the three descriptor strings, two registered reads.
`timescale 1ns/10ps
`include "hdpc_regs.svh"
module hdpc_text_mem
	import hdpc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_index,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] cfg_index,
	output logic [7:0] cfg_data,
	input wire logic [7:0] desc_index,
	output logic [7:0] desc_data
);
	typedef struct packed {
		logic [`HDPC_TEXT_BYTES-1:0][7:0] bytes;
		logic [7:0] cfg_q;
		logic [7:0] desc_q;
	} hdpc_mem_s;

	hdpc_mem_s s;
	hdpc_mem_s next_s;

	// Out-of-range indexes read zero so no read ever leaves the array.
	always_comb begin
		next_s = s;
		if (wr_en && wr_index < 8'(`HDPC_TEXT_BYTES)) begin
			next_s.bytes[wr_index] = wr_data; // [R15]
		end
		next_s.cfg_q = (cfg_index < 8'(`HDPC_TEXT_BYTES)) ?
			s.bytes[cfg_index] : 8'h00;
		next_s.desc_q = (desc_index < 8'(`HDPC_TEXT_BYTES)) ?
			s.bytes[desc_index] : 8'h00;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) s <= '0;
		else s <= next_s;
	end

	assign cfg_data = s.cfg_q;
	assign desc_data = s.desc_q;
endmodule // hdpc_text_mem

// ### hdpc_unit_scale.sv
// Turns a count of two-unit steps into the represented quantity.
`timescale 1ns/10ps
module hdpc_unit_scale
	import hdpc_pkg::*;
(
	input wire logic [7:0] count,
	output logic [8:0] amount
);
	assign amount = {count, 1'b0}; // [R01] [R04] [R08]
endmodule // hdpc_unit_scale

// ### hdpc_bank_monitor.sv
// Concurrent checks on the ports of the hub descriptor config bank.
`timescale 1ns/10ps
module hdpc_bank_monitor
	import hdpc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire hdpc_cfg_req_s cfg_req,
	input wire logic [7:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic desc_req,
	input wire hdpc_desc_sel_e desc_sel,
	input wire logic desc_ready,
	input wire hdpc_desc_out_s desc_out,
	input wire logic desc_busy,
	input wire hdpc_power_s power,
	input wire logic [8:0] self_powered_current_ma,
	input wire logic [8:0] bus_powered_current_ma,
	input wire logic [8:0] port_power_settle_ms
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_lang_req;
		desc_req && !desc_busy && desc_sel == HDPC_DESC_LANG;
	endsequence
	sequence s_lang_low;
		desc_out.valid && !desc_out.last &&
			desc_out.data == power.language_id[7:0];
	endsequence

	a_self_scale: assert property (self_powered_current_ma ==
		{power.self_count, 1'b0}) else $error("self current scale wrong");
	a_bus_scale: assert property (bus_powered_current_ma ==
		{power.bus_count, 1'b0}) else $error("bus current scale wrong");
	a_settle_scale: assert property (port_power_settle_ms ==
		{power.settle_count, 1'b0}) else $error("settle scale wrong");
	a_self_write: assert property (cfg_req.write &&
		cfg_req.addr == 8'h0E |=> power.self_count == $past(cfg_req.wdata))
		else $error("self current write lost");
	a_lang_high: assert property (cfg_req.write &&
		cfg_req.addr == 8'h11 |=>
		power.language_id[15:8] == $past(cfg_req.wdata))
		else $error("language high write lost");
	a_self_read: assert property (cfg_req.read && !cfg_req.write &&
		cfg_req.addr == 8'h0E |-> ##2 cfg_rvalid &&
		cfg_rdata == $past(power.self_count, 2))
		else $error("self current read wrong");
	a_lang_start: assert property (s_lang_req |=> s_lang_low)
		else $error("language low byte not first");
	a_lang_second: assert property (s_lang_req ##1
		(s_lang_low and desc_ready) |=> desc_out.valid && desc_out.last &&
		desc_out.data == power.language_id[15:8])
		else $error("language high byte wrong");
	a_byte_hold: assert property (desc_out.valid && !desc_ready |=>
		desc_out.valid && $stable(desc_out.data) && $stable(desc_out.last))
		else $error("descriptor byte dropped while stalled");
	a_last_done: assert property (desc_out.valid &&
		desc_out.last && desc_ready |=> !desc_busy && !desc_out.valid)
		else $error("transfer not ended after last byte");
endmodule // hdpc_bank_monitor

// ### hdpc_host_model.sv
// Upstream host model that takes descriptor bytes, promptly or with stalls.
`timescale 1ns/10ps
module hdpc_host_model
	import hdpc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire hdpc_desc_out_s desc_out,
	input wire logic slow,
	output logic desc_ready
);
	logic [7:0] got[$];

	initial desc_ready = 1'b0;
	always @(negedge clock) begin
		desc_ready <= reset_n && (!slow || $urandom_range(1) == 1);
	end
	// Bytes are kept in arrival order, so low byte precedes high byte.
	always @(posedge clock) begin
		if (reset_n && desc_out.valid && desc_ready)
			got.push_back(desc_out.data);
	end
endmodule // hdpc_host_model

// ### tb_top.sv
// Self-checking bench for the hub descriptor config bank.
`timescale 1ns/10ps
module tb_top
	import hdpc_pkg::*;
;
	logic clock, reset_n, desc_req, slow, desc_ready, cfg_rvalid, desc_busy;
	hdpc_cfg_req_s cfg_req;
	hdpc_desc_sel_e desc_sel;
	hdpc_desc_out_s desc_out;
	hdpc_power_s power;
	logic [7:0] cfg_rdata;
	logic [8:0] self_ma, bus_ma, settle_ms;
	int err_total, checks;
	int mem [256];
	int exp_q[$];
	int lens [8] = '{0, 0, 31, 40, 0, 2, 1, 31};

	hdpc_bank dut (.clock(clock), .reset_n(reset_n), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .desc_req(desc_req),
		.desc_sel(desc_sel), .desc_ready(desc_ready), .desc_out(desc_out),
		.desc_busy(desc_busy), .power(power), .self_powered_current_ma(self_ma),
		.bus_powered_current_ma(bus_ma), .port_power_settle_ms(settle_ms));
	hdpc_host_model host (.clock(clock), .reset_n(reset_n),
		.desc_out(desc_out), .slow(slow), .desc_ready(desc_ready));

	task automatic chk(input string name, input int exp,
		input logic [15:0] seen);
		checks++;
		if (seen !== 16'(exp)) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic wr(input int a, input int d);
		@(negedge clock);
		cfg_req = '{1'b1, 1'b0, 8'(a), 8'(d)};
		if (a >= 'h0E && a <= 'hCF)
			mem[a] = d;
	endtask
	task automatic rd(input int a);
		@(negedge clock);
		cfg_req = '{1'b0, 1'b1, 8'(a), 8'h00};
		@(negedge clock);
		cfg_req = '0;
		// The answer stands one cycle, one edge after the request is taken.
		@(negedge clock);
		chk("rdata", 'h100 | mem[a], {7'h00, cfg_rvalid, cfg_rdata});
	endtask
	task automatic desc(input int s);
		int n, b;
		exp_q.delete();
		host.got.delete();
		if (s == 0)
			exp_q = '{mem['h12], mem['h11]};
		else begin
			n = mem['h12 + s] > 31 ? 31 : mem['h12 + s];
			b = 'h16 + (s - 1) * 62;
			for (int i = 0; i < 2 * n; i++)
				exp_q.push_back(mem[b + i]);
		end
		@(negedge clock);
		cfg_req = '0;
		desc_req = 1'b1;
		desc_sel = hdpc_desc_sel_e'(s);
		@(negedge clock);
		desc_req = 1'b0;
		for (int i = 0; i < 1000 && desc_busy !== 1'b0; i++)
			@(negedge clock);
		chk("desc_busy", 0, {15'h0000, desc_busy});
		chk("desc_count", exp_q.size(), 16'(host.got.size()));
		foreach (exp_q[i])
			chk("desc_byte", exp_q[i], {8'h00, host.got[i]});
	endtask
	task automatic print_verdict();
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// The whole run needs under 8000 cycles; the limit leaves ample margin.
	initial begin
		#(100 * 20000);
		err_total++;
		print_verdict();
	end
	initial begin
		void'($urandom(54463));
		reset_n = 1'b0;
		cfg_req = '0;
		desc_req = 1'b0;
		desc_sel = HDPC_DESC_LANG;
		slow = 1'b0;
		foreach (mem[a])
			mem[a] = (a == 'h0E || a == 'h0F) ? 'h32 : 0;
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		for (int a = 0; a < 256; a++)
			rd(a);
		for (int a = 0; a < 256; a++)
			wr(a, a == 'h0E ? $urandom_range(50) : $urandom_range(255));
		for (int a = 0; a < 256; a++)
			rd(a);
		chk("self_ma", 2 * mem['h0E], 16'(self_ma));
		chk("bus_ma", 2 * mem['h0F], 16'(bus_ma));
		chk("settle_ms", 2 * mem['h10], 16'(settle_ms));
		chk("lang_id", mem['h11] * 256 + mem['h12],
			power.language_id);
		for (int k = 0; k < 8; k++) begin
			slow = k >= 4;
			if (k % 4 != 0)
				wr('h12 + k % 4, lens[k]);
			desc(k % 4);
		end
		print_verdict();
	end
endmodule // tb_top

bind hdpc_bank hdpc_bank_monitor mon (.clock(clock), .reset_n(reset_n),
	.cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
	.desc_req(desc_req), .desc_sel(desc_sel), .desc_ready(desc_ready),
	.desc_out(desc_out), .desc_busy(desc_busy), .power(power),
	.self_powered_current_ma(self_powered_current_ma),
	.bus_powered_current_ma(bus_powered_current_ma),
	.port_power_settle_ms(port_power_settle_ms));
